// file: scg_serial_ctrl.sv
// Serial port control register, status flags and interrupt gating.
// Assumes a classic Wishbone master; shifter events come in as one-cycle pulses.
`timescale 1ns/100ps
module scg_serial_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic standby_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic tx_load_i,
    input wire logic tx_last_bit_i,
    input wire logic rx_done_i,
    input wire logic rx_fer_i,
    input wire logic rx_per_i,
    input wire logic rx_mpb_i,
    input wire logic rx_start_i,
    output logic tx_start_o,
    output logic tx_busy_o,
    output logic rx_active_o,
    output logic rx_store_o,
    output logic ext_clk_sel_o,
    output logic sck_drive_o,
    output logic tx_empty_irq_o,
    output logic rx_full_irq_o,
    output logic rx_error_irq_o,
    output logic tx_end_irq_o
);

    // ****************************************
    // Declarations
    // ****************************************
    scg_ctrl_if c();
    scg_pkg::scg_bus_state_t bus_reg;
    logic [7:0] serial_control_reg;
    logic [7:0] serial_status_reg;
    logic [7:0] serial_mode_reg;
    logic [7:0] armed_reg;
    logic [7:0] sw_status;
    logic [5:0] ev;
    logic wr_hit, rd_hit, lane0, clr;
    logic tx_load, tx_last, rx_done, rx_fer, rx_per, rx_mpb;
    logic hunting, accept, mpb_frame, te, re;

    // ****************************************
    // Wishbone slave
    // ****************************************
    // One wait state: ack in the cycle after stb is seen, then one idle cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_reg <= scg_pkg::scg_bus_idle;
        end else begin
            case (bus_reg)
                scg_pkg::scg_bus_idle: if (wb_cyc_i && wb_stb_i) bus_reg <= scg_pkg::scg_bus_ack;
                scg_pkg::scg_bus_ack: bus_reg <= scg_pkg::scg_bus_gap;
                scg_pkg::scg_bus_gap: bus_reg <= scg_pkg::scg_bus_idle;
                default: bus_reg <= scg_pkg::scg_bus_idle;
            endcase
        end
    end

    logic mapped;
    always_comb begin
        mapped = (wb_adr_i == scg_pkg::ctrl_offset) || (wb_adr_i == scg_pkg::status_offset)
            || (wb_adr_i == scg_pkg::mode_offset) || (wb_adr_i == scg_pkg::event_offset);
    end

    assign wb_ack_o = (bus_reg == scg_pkg::scg_bus_ack) && wb_cyc_i && wb_stb_i && mapped;
    assign wb_err_o = (bus_reg == scg_pkg::scg_bus_ack) && wb_cyc_i && wb_stb_i && !mapped;
    assign lane0 = wb_sel_i[0];
    assign wr_hit = wb_ack_o && wb_we_i && lane0;
    assign rd_hit = wb_ack_o && !wb_we_i;
    assign clr = standby_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if ((bus_reg == scg_pkg::scg_bus_idle) && wb_cyc_i && wb_stb_i && !wb_we_i) begin
            case (wb_adr_i)
                scg_pkg::ctrl_offset: wb_dat_o <= scg_pkg::scg_widen(serial_control_reg);
                scg_pkg::status_offset: wb_dat_o <= scg_pkg::scg_widen(serial_status_reg);
                scg_pkg::mode_offset: wb_dat_o <= scg_pkg::scg_widen(serial_mode_reg);
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // ****************************************
    // Event injection and qualification
    // ****************************************
    assign ev = (wr_hit && wb_adr_i == scg_pkg::event_offset) ? wb_dat_i[5:0] : 6'h00;
    assign te = serial_control_reg[scg_pkg::ctl_te];
    assign re = serial_control_reg[scg_pkg::ctl_re];
    assign c.async_mp = !serial_mode_reg[scg_pkg::md_sync] && serial_mode_reg[scg_pkg::md_mp];
    assign hunting = serial_control_reg[scg_pkg::ctl_multiproc_irq_enable] && c.async_mp;
    assign tx_load = te && !serial_status_reg[scg_pkg::st_tx_empty_flag] && (tx_load_i || ev[scg_pkg::ev_load]);
    assign tx_last = te && (tx_last_bit_i || ev[scg_pkg::ev_last_bit]);
    assign rx_done = re && (rx_done_i || ev[scg_pkg::ev_rx_done]);
    assign rx_fer = rx_fer_i || ev[scg_pkg::ev_rx_fer];
    assign rx_per = rx_per_i || ev[scg_pkg::ev_rx_per];
    assign rx_mpb = rx_mpb_i || ev[scg_pkg::ev_rx_mpb];
    assign mpb_frame = rx_done && c.async_mp && rx_mpb;
    // Frames are dropped while hunting unless they carry the marker bit
    assign accept = rx_done && (!hunting || mpb_frame);

    // ****************************************
    // Control and mode registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i || clr) begin
            serial_control_reg <= scg_pkg::ctrl_reset;
        end else begin
            if (wr_hit && wb_adr_i == scg_pkg::ctrl_offset) begin
                serial_control_reg <= wb_dat_i[7:0];
            end
            if (hunting && mpb_frame) begin
                serial_control_reg[scg_pkg::ctl_multiproc_irq_enable] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || clr) begin
            serial_mode_reg <= scg_pkg::mode_reset;
        end else if (wr_hit && wb_adr_i == scg_pkg::mode_offset) begin
            serial_mode_reg <= wb_dat_i[7:0];
        end
    end

    // ****************************************
    // Status flags
    // ****************************************
    // A flag may be cleared only after being read as one; arm on read
    always_ff @(posedge clk_i) begin
        if (rst_i || clr) begin
            armed_reg <= 8'h00;
        end else if (rd_hit && wb_adr_i == scg_pkg::status_offset) begin
            armed_reg <= armed_reg | serial_status_reg;
        end else if (wr_hit && wb_adr_i == scg_pkg::status_offset) begin
            armed_reg <= armed_reg & wb_dat_i[7:0];
        end
    end

    // Written zero on an armed bit clears it; tx-end and mp bit are read-only
    localparam logic [7:0] read_only_mask = 8'h07;
    assign sw_status = (wr_hit && wb_adr_i == scg_pkg::status_offset)
        ? (serial_status_reg & (wb_dat_i[7:0] | ~armed_reg | read_only_mask)) : serial_status_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i || clr) begin
            serial_status_reg <= scg_pkg::status_reset;
        end else begin
            serial_status_reg <= sw_status;
            // Hardware sets after the software clear so a same-cycle event wins
            if (!te) begin
                serial_status_reg[scg_pkg::st_tx_empty_flag] <= 1'b1;
            end else if (tx_load) begin
                serial_status_reg[scg_pkg::st_tx_empty_flag] <= 1'b1;
            end
            if (tx_load) begin
                serial_status_reg[scg_pkg::st_tend] <= 1'b0;
            end else if (tx_last && serial_status_reg[scg_pkg::st_tx_empty_flag]) begin
                serial_status_reg[scg_pkg::st_tend] <= 1'b1;
            end else if (!te) begin
                serial_status_reg[scg_pkg::st_tend] <= 1'b1;
            end
            // Full and error flags move only on accepted frames, the mp bit on every async mp frame; receive enable clear leaves them
            if (accept) begin
                if (serial_status_reg[scg_pkg::st_rx_full_flag]) begin
                    serial_status_reg[scg_pkg::st_overrun_flag] <= 1'b1;
                end else if (rx_fer) begin
                    serial_status_reg[scg_pkg::st_fer] <= 1'b1;
                end else if (rx_per && !c.async_mp) begin
                    serial_status_reg[scg_pkg::st_per] <= 1'b1;
                end else begin
                    serial_status_reg[scg_pkg::st_rx_full_flag] <= 1'b1;
                end
            end
            if (rx_done && c.async_mp) begin
                serial_status_reg[scg_pkg::st_mpb] <= rx_mpb;
            end
        end
    end

    // ****************************************
    // Shifter handshakes
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i || clr) begin
            tx_start_o <= 1'b0;
            tx_busy_o <= 1'b0;
            rx_active_o <= 1'b0;
            rx_store_o <= 1'b0;
        end else begin
            tx_start_o <= tx_load;
            tx_busy_o <= te && (tx_load || (tx_busy_o && !tx_last));
            rx_active_o <= re && (rx_start_i || (rx_active_o && !rx_done));
            rx_store_o <= accept && !serial_status_reg[scg_pkg::st_rx_full_flag]
                && !rx_fer && !(rx_per && !c.async_mp);
        end
    end

    // ****************************************
    // Interrupt gating and clock select
    // ****************************************
    assign c.ctrl = serial_control_reg;
    assign c.status = serial_status_reg;

    scg_irq_gate u_gate (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .c(c)
    );

    scg_clk_sel u_clk (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .c(c),
        .sync_mode_i(serial_mode_reg[scg_pkg::md_sync]),
        .ext_clk_sel_o(ext_clk_sel_o),
        .sck_drive_o(sck_drive_o)
    );

    assign tx_empty_irq_o = c.irq_tx_empty;
    assign rx_full_irq_o = c.irq_rx_full;
    assign rx_error_irq_o = c.irq_rx_err;
    assign tx_end_irq_o = c.irq_tx_end;

endmodule // scg_serial_ctrl

// file: scg_pkg.sv
// Constants for the serial control and interrupt gating block.
// Assumes a 32-bit classic Wishbone register bus and a single 200 MHz clock.
package scg_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] ctrl_offset = 4'h0;
    localparam logic [3:0] status_offset = 4'h4;
    localparam logic [3:0] mode_offset = 4'h8;
    localparam logic [3:0] event_offset = 4'hc;
    localparam logic [7:0] ctrl_reset = 8'h00;
    localparam logic [7:0] status_reset = 8'h84;
    localparam logic [7:0] mode_reset = 8'h00;

    // ****************************************
    // Control fields
    // ****************************************
    localparam int ctl_tie = 7;
    localparam int ctl_rie = 6;
    localparam int ctl_te = 5;
    localparam int ctl_re = 4;
    localparam int ctl_multiproc_irq_enable = 3;
    localparam int ctl_tx_end_irq_enable = 2;
    localparam int ctl_clock_source_sel = 1;
    localparam int ctl_clock_output_sel = 0;

    // ****************************************
    // Status fields
    // ****************************************
    localparam int st_tx_empty_flag = 7;
    localparam int st_rx_full_flag = 6;
    localparam int st_overrun_flag = 5;
    localparam int st_fer = 4;
    localparam int st_per = 3;
    localparam int st_tend = 2;
    localparam int st_mpb = 1;

    // ****************************************
    // Mode fields
    // ****************************************
    localparam int md_sync = 7;
    localparam int md_mp = 2;

    // ****************************************
    // Event register fields (write 1 to inject)
    // ****************************************
    localparam int ev_load = 0;
    localparam int ev_last_bit = 1;
    localparam int ev_rx_done = 2;
    localparam int ev_rx_fer = 3;
    localparam int ev_rx_per = 4;
    localparam int ev_rx_mpb = 5;

    typedef enum logic [1:0] {
        scg_bus_idle,
        scg_bus_ack,
        scg_bus_gap
    } scg_bus_state_t;

    function automatic logic [31:0] scg_widen(input logic [7:0] v);
        return {24'h000000, v};
    endfunction

endpackage

// file: scg_ctrl_if.sv
// Interface carrying control bits from the register file to the gating logic.
// Assumes both ends sit in the clk_i domain.
`timescale 1ns/100ps
interface scg_ctrl_if;
    logic [7:0] ctrl;
    logic [7:0] status;
    logic async_mp;
    logic irq_tx_empty;
    logic irq_rx_full;
    logic irq_rx_err;
    logic irq_tx_end;

    modport regs (output ctrl, output async_mp, input status,
                  input irq_tx_empty, input irq_rx_full, input irq_rx_err, input irq_tx_end);
    modport gate (input ctrl, input async_mp, input status,
                  output irq_tx_empty, output irq_rx_full, output irq_rx_err, output irq_tx_end);
endinterface

// file: scg_irq_gate.sv
// Level interrupt gating: flag AND enable every cycle.
// Assumes status and control are already registered.
`timescale 1ns/100ps
module scg_irq_gate (
    input wire logic clk_i,
    input wire logic rst_i,
    scg_ctrl_if.gate c
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            c.irq_tx_empty <= 1'b0;
            c.irq_rx_full <= 1'b0;
            c.irq_rx_err <= 1'b0;
            c.irq_tx_end <= 1'b0;
        end else begin
            c.irq_tx_empty <= c.ctrl[scg_pkg::ctl_tie] & c.status[scg_pkg::st_tx_empty_flag];
            c.irq_rx_full <= c.ctrl[scg_pkg::ctl_rie] & c.status[scg_pkg::st_rx_full_flag];
            c.irq_rx_err <= c.ctrl[scg_pkg::ctl_rie]
                & (c.status[scg_pkg::st_overrun_flag] | c.status[scg_pkg::st_fer] | c.status[scg_pkg::st_per]);
            c.irq_tx_end <= c.ctrl[scg_pkg::ctl_tx_end_irq_enable] & c.status[scg_pkg::st_tend];
        end
    end
endmodule // scg_irq_gate

// file: scg_clk_sel.sv
// Serial clock pin direction selection from the clock-enable bits.
// Assumes the mode bit is stable while the port is in use.
`timescale 1ns/100ps
module scg_clk_sel (
    input wire logic clk_i,
    input wire logic rst_i,
    scg_ctrl_if.gate c,
    input wire logic sync_mode_i,
    output logic ext_clk_sel_o,
    output logic sck_drive_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_clk_sel_o <= 1'b0;
            sck_drive_o <= 1'b0;
        end else begin
            ext_clk_sel_o <= c.ctrl[scg_pkg::ctl_clock_source_sel];
            // Sync mode always drives on internal clock; async only when selected
            sck_drive_o <= ~c.ctrl[scg_pkg::ctl_clock_source_sel]
                & (sync_mode_i | c.ctrl[scg_pkg::ctl_clock_output_sel]);
        end
    end
endmodule // scg_clk_sel

// file: scg_remote.sv
// Remote serial device model: shifter events as one-cycle strobes.
// Assumes its tasks are called just after a rising clk_i edge.
`timescale 1ns/100ps
module scg_remote (
    input wire logic clk_i,
    output logic tx_load_o,
    output logic tx_last_bit_o,
    output logic rx_done_o,
    output logic rx_fer_o,
    output logic rx_per_o,
    output logic rx_mpb_o,
    output logic rx_start_o
);
    logic [3:0] ev = 4'h0;
    logic [2:0] qual = 3'h5;
    assign {rx_start_o, rx_done_o, tx_last_bit_o, tx_load_o} = ev;
    assign {rx_fer_o, rx_per_o, rx_mpb_o} = qual;

    task automatic pulse(input logic [3:0] m);
        ev <= m;
        @(posedge clk_i);
        ev <= 4'h0;
    endtask

    task automatic frame(input logic [2:0] f);
        pulse(4'h8);
        @(posedge clk_i);
        qual <= f;
        pulse(4'h4);
        // Qualifiers mean nothing outside the done strobe
        qual <= ~f;
    endtask
endmodule // scg_remote

// file: scg_properties.sv
// Concurrent checks on the serial control block ports.
// Assumes one clock domain; standby clears like reset.
`timescale 1ns/100ps
module scg_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic standby_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic tx_start_o,
    input wire logic rx_active_o,
    input wire logic ext_clk_sel_o,
    input wire logic tx_empty_irq_o,
    input wire logic rx_full_irq_o,
    input wire logic rx_error_irq_o,
    input wire logic tx_end_irq_o
);
    // Shadow of written control bits; hardware clear of bit 3 not tracked
    logic [7:0] sh_reg;
    logic sh_te;
    logic sh_re;
    logic sh_c1;
    assign sh_te = sh_reg[5];
    assign sh_re = sh_reg[4];
    assign sh_c1 = sh_reg[1];
    always_ff @(posedge clk_i) begin
        if (rst_i || standby_i) begin
            sh_reg <= 8'h00;
        end else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == scg_pkg::ctrl_offset) begin
            sh_reg <= wb_dat_i[7:0];
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i || standby_i);

    // ****
    // Properties
    // ****
    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held too long");
    property p_answer;
        $rose(wb_stb_i) |=> (wb_ack_o ^ wb_err_o);
    endproperty
    a_answer: assert property (p_answer) else $error("no single answer");
    property p_txi_set;
        tx_start_o && sh_reg[7] |=> tx_empty_irq_o;
    endproperty
    a_txi_set: assert property (p_txi_set) else $error("tx empty irq missing");
    property p_txi_gate;
        !sh_reg[7] ##1 !sh_reg[7] |-> !tx_empty_irq_o;
    endproperty
    a_txi_gate: assert property (p_txi_gate) else $error("tx empty irq ungated");
    property p_rxi_gate;
        !sh_reg[6] ##1 !sh_reg[6] |-> !rx_full_irq_o;
    endproperty
    a_rxi_gate: assert property (p_rxi_gate) else $error("rx full irq ungated");
    property p_eri_gate;
        !sh_reg[6] ##1 !sh_reg[6] |-> !rx_error_irq_o;
    endproperty
    a_eri_gate: assert property (p_eri_gate) else $error("rx error irq ungated");
    property p_tei_gate;
        !sh_reg[2] ##1 !sh_reg[2] |-> !tx_end_irq_o;
    endproperty
    a_tei_gate: assert property (p_tei_gate) else $error("tx end irq ungated");
    property p_te_start;
        tx_start_o |-> $past(sh_te);
    endproperty
    a_te_start: assert property (p_te_start) else $error("start while disabled");
    property p_re_rx;
        $rose(rx_active_o) |-> $past(sh_re);
    endproperty
    a_re_rx: assert property (p_re_rx) else $error("receive while disabled");
    property p_clock_source_sel;
        ext_clk_sel_o == $past(sh_c1);
    endproperty
    a_clock_source_sel: assert property (p_clock_source_sel) else $error("clock source mismatch");
    c_txi: cover property (tx_empty_irq_o);
    c_rxi: cover property (rx_full_irq_o && rx_error_irq_o);
    c_err: cover property (wb_err_o);
endmodule // scg_properties

bind scg_serial_ctrl scg_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .standby_i(standby_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .tx_start_o(tx_start_o), .rx_active_o(rx_active_o),
    .ext_clk_sel_o(ext_clk_sel_o), .tx_empty_irq_o(tx_empty_irq_o), .rx_full_irq_o(rx_full_irq_o),
    .rx_error_irq_o(rx_error_irq_o), .tx_end_irq_o(tx_end_irq_o));

// file: testbench.sv
// Self-checking bench for the serial control block.
// Assumes scg_pkg, the design files, model and checker are compiled first.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("BAD %0t got %h want %h", $time, g, e); end end
module testbench;
    logic clk_i, rst_i, standby_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o;
    logic [3:0] wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic tx_load_i, tx_last_bit_i, rx_done_i, rx_fer_i, rx_per_i, rx_mpb_i, rx_start_i;
    logic tx_start_o, tx_busy_o, rx_active_o, rx_store_o, ext_clk_sel_o, sck_drive_o;
    logic tx_empty_irq_o, rx_full_irq_o, rx_error_irq_o, tx_end_irq_o;
    logic [7:0] q;
    logic e;
    int n_fail = 0;
    int samples_checked = 0;
    localparam logic [3:0] C = scg_pkg::ctrl_offset;
    localparam logic [3:0] S = scg_pkg::status_offset;
    localparam logic [3:0] M = scg_pkg::mode_offset;

    scg_serial_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .standby_i(standby_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .tx_load_i(tx_load_i),
        .tx_last_bit_i(tx_last_bit_i), .rx_done_i(rx_done_i), .rx_fer_i(rx_fer_i), .rx_per_i(rx_per_i),
        .rx_mpb_i(rx_mpb_i), .rx_start_i(rx_start_i), .tx_start_o(tx_start_o), .tx_busy_o(tx_busy_o),
        .rx_active_o(rx_active_o), .rx_store_o(rx_store_o), .ext_clk_sel_o(ext_clk_sel_o),
        .sck_drive_o(sck_drive_o), .tx_empty_irq_o(tx_empty_irq_o), .rx_full_irq_o(rx_full_irq_o),
        .rx_error_irq_o(rx_error_irq_o), .tx_end_irq_o(tx_end_irq_o));
    scg_remote peer (.clk_i(clk_i), .tx_load_o(tx_load_i), .tx_last_bit_o(tx_last_bit_i),
        .rx_done_o(rx_done_i), .rx_fer_o(rx_fer_i), .rx_per_o(rx_per_i), .rx_mpb_o(rx_mpb_i),
        .rx_start_o(rx_start_i));

    task automatic summarize();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Classic cycle; returns after the one-cycle gap the slave needs
    task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= {24'h000000, d};
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (!(wb_ack_o || wb_err_o) && n < 40);
        if (n >= 40) n_fail++;
        q = wb_dat_o[7:0];
        e = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic w(input int k);
        repeat (k) @(posedge clk_i);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        summarize();
    end

    // ****
    // Tests
    // ****
    initial begin
        {rst_i, standby_i, wb_we_i, wb_cyc_i, wb_stb_i} = 5'h10;
        wb_adr_i = 4'h0;
        wb_dat_i = 32'h00000000;
        wb_sel_i = 4'h1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(C, 0, 8'h00); `CHK(q, 8'h00)
        bus(S, 0, 8'h00); `CHK(q, scg_pkg::status_reset)
        bus(C, 1, 8'hf7); bus(C, 0, 8'h00); `CHK(q, 8'hf7)
        bus(4'h2, 0, 8'h00); `CHK(e, 1'b1)
        bus(C, 1, 8'ha5);
        standby_i <= 1'b1;
        w(1);
        standby_i <= 1'b0;
        w(1);
        bus(C, 0, 8'h00); `CHK(q, 8'h00)
        wb_sel_i <= 4'h0;
        bus(C, 1, 8'hff);
        wb_sel_i <= 4'h1;
        bus(C, 0, 8'h00); `CHK(q, 8'h00)
        bus(M, 1, 8'h00);
        bus(C, 1, 8'ha0); w(3); `CHK(tx_empty_irq_o, 1'b1)
        bus(S, 0, 8'h00); bus(S, 1, 8'h00); w(3); `CHK(tx_empty_irq_o, 1'b0)
        peer.pulse(4'h1); w(1); `CHK(tx_start_o, 1'b1)
        `CHK(tx_busy_o, 1'b1)
        w(3); `CHK(tx_empty_irq_o, 1'b1)
        bus(C, 1, 8'h20); w(3); `CHK(tx_empty_irq_o, 1'b0)
        bus(C, 1, 8'h24); peer.pulse(4'h2); w(3); `CHK(tx_end_irq_o, 1'b1)
        `CHK(tx_busy_o, 1'b0)
        bus(C, 1, 8'h20); w(3); `CHK(tx_end_irq_o, 1'b0)
        bus(C, 1, 8'h00); bus(S, 0, 8'h00); `CHK(q[7], 1'b1)
        bus(C, 1, 8'h50);
        peer.frame(3'h0); w(1); `CHK(rx_store_o, 1'b1)
        w(2); `CHK(rx_full_irq_o, 1'b1)
        peer.frame(3'h0); w(3); `CHK(rx_error_irq_o, 1'b1)
        bus(C, 1, 8'h40); bus(S, 0, 8'h00); `CHK(q & 8'h60, 8'h60)
        bus(S, 1, 8'h00); w(3); `CHK({rx_full_irq_o, rx_error_irq_o}, 2'b00)
        bus(M, 1, 8'h04); bus(C, 1, 8'h58);
        peer.frame(3'h0); w(3); `CHK(rx_full_irq_o, 1'b0)
        bus(S, 0, 8'h00); `CHK(q[6], 1'b0)
        peer.frame(3'h1); w(3); `CHK(rx_full_irq_o, 1'b1)
        bus(S, 0, 8'h00); `CHK(q[1], 1'b1)
        bus(S, 1, 8'h00); bus(S, 0, 8'h00); `CHK(q[1], 1'b1)
        bus(C, 0, 8'h00); `CHK(q, 8'h50)
        bus(S, 1, 8'h00); bus(M, 1, 8'h84); bus(C, 1, 8'h58);
        peer.frame(3'h0); w(3); bus(S, 0, 8'h00); `CHK(q[6], 1'b1)
        bus(M, 1, 8'h00); bus(C, 1, 8'h02); w(3); `CHK({ext_clk_sel_o, sck_drive_o}, 2'b10)
        bus(C, 1, 8'h01); w(3); `CHK({ext_clk_sel_o, sck_drive_o}, 2'b01)
        bus(S, 0, 8'h00); bus(S, 1, 8'h00); bus(C, 1, 8'h50);
        peer.frame(3'h4); w(1); `CHK(rx_store_o, 1'b0)
        w(2); `CHK(rx_error_irq_o, 1'b1)
        bus(S, 0, 8'h00); `CHK(q[4], 1'b1)
        peer.frame(3'h2); w(3); bus(S, 0, 8'h00); `CHK(q[3], 1'b1)
        summarize();
    end
endmodule // testbench
